// ---- hdl/vector_map_params.svh ----
// Purpose: constants for the reset and interrupt vector address map
// Assumes: word addresses of program memory
// Notes:   vector offsets are one word apart
`ifndef VECTOR_MAP_PARAMS_SVH
`define VECTOR_MAP_PARAMS_SVH

`define ADDR_WIDTH        12
`define SOURCE_COUNT      25
`define RESET_OFFSET      12'h000
`define FIRST_VEC_OFFSET  12'h001
`define LAST_VEC_OFFSET   12'h019
`define FUSE_PROGRAMMED   1'b0
`define FUSE_UNPROGRAMMED 1'b1

`endif

// ---- hdl/vector_map_pkg.sv ----
// Purpose: types for the reset and interrupt vector address map
// Assumes: params header supplies the widths
// Notes:   none
`include "vector_map_params.svh"

package vector_map_pkg;

  typedef logic [`ADDR_WIDTH-1:0]   word_addr_type;
  typedef logic [`SOURCE_COUNT-1:0] irq_vec_type;

  typedef enum logic
  {
    DISPATCH_RESET,
    DISPATCH_IRQ
  } dispatch_kind_type;

endpackage : vector_map_pkg

// ---- hdl/interrupt_vector_address_map.sv ----
// Purpose: program address generator for reset and interrupt dispatch
// Assumes: request lines are on the core clock and already enabled
// Notes:   one word per vector slot; word addresses throughout
`timescale 1ns/1ps
`default_nettype none
`include "vector_map_params.svh"

module interrupt_vector_address_map
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          reset_req,
  input  wire logic                          boot_reset_fuse,
  input  wire logic                          vector_relocate_bit,
  input  wire vector_map_pkg::word_addr_type boot_start,
  input  wire vector_map_pkg::irq_vec_type   irq_pending,
  output var  logic                          target_valid,
  output var  vector_map_pkg::dispatch_kind_type target_kind,
  output var  vector_map_pkg::word_addr_type target_addr,
  output var  logic [4:0]                    target_source
);
  import vector_map_pkg::*;

  // ==========================================================
  // source index to vector slot
  // ==========================================================
  // bit i of irq_pending is source at slot i+1:
  // 0 ext_irq_zero, 1 ext_irq_one, 2..4 pin_change_group_a..c,
  // 5 watchdog_timeout_irq, 6..8 timer2, 9..12 timer1,
  // 13..15 timer0, 16 spi, 17 rx, 18 tx_buffer_empty, 19 tx,
  // 20 adc, 21 eeprom_done_irq, 22 comparator, 23 two_wire_irq,
  // 24 self_program_store_done
  // slots only matter when a request asks for them

  logic                  found;
  logic [4:0]            winner;
  word_addr_type         slot;
  word_addr_type         vec_base;
  word_addr_type         reset_addr;
  logic                  next_target_valid;
  dispatch_kind_type     next_target_kind;
  word_addr_type         next_target_addr;
  logic [4:0]            next_target_source;

  always_comb
  begin
    found  = 1'b0;
    winner = 5'h00;
    for (int i = `SOURCE_COUNT - 1; i >= 0; i--)
    begin
      if (irq_pending[i])
      begin
        found  = 1'b1;
        winner = 5'(i);
      end
    end
    slot = `FIRST_VEC_OFFSET + word_addr_type'(winner);
    vec_base   = vector_relocate_bit ? boot_start : `RESET_OFFSET;
    reset_addr = (boot_reset_fuse == `FUSE_PROGRAMMED)
                 ? boot_start : `RESET_OFFSET;
  end

  // ==========================================================
  // dispatch register
  // ==========================================================
  always_comb
  begin
    next_target_valid  = 1'b0;
    next_target_kind   = DISPATCH_RESET;
    next_target_addr   = `RESET_OFFSET;
    next_target_source = 5'h00;
    if (reset_req)
    begin
      next_target_valid = 1'b1;
      next_target_addr  = reset_addr;
    end
    else if (found)
    begin
      next_target_valid  = 1'b1;
      next_target_kind   = DISPATCH_IRQ;
      next_target_addr   = vec_base + slot;
      next_target_source = winner;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      target_valid  <= 1'b0;
      target_kind   <= DISPATCH_RESET;
      target_addr   <= `RESET_OFFSET;
      target_source <= 5'h00;
    end
    else
    begin
      target_valid  <= next_target_valid;
      target_kind   <= next_target_kind;
      target_addr   <= next_target_addr;
      target_source <= next_target_source;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  AST_RESET_ADDR: assert property (@(posedge clk) disable iff (rst)
    reset_req |=> target_valid && target_kind == DISPATCH_RESET
      && target_addr == ($past(boot_reset_fuse) ? 12'h000
                                                : $past(boot_start)))
    else $error("reset target address wrong");

  AST_RESET_ZERO: assert property (@(posedge clk) disable iff (rst)
    reset_req && boot_reset_fuse |=> target_addr == 12'h000)
    else $error("unprogrammed fuse must reset to zero");

  AST_RESET_BOOT: assert property (@(posedge clk) disable iff (rst)
    reset_req && !boot_reset_fuse |=> target_addr == $past(boot_start))
    else $error("programmed fuse must reset to boot start");

  AST_EXT0: assert property (@(posedge clk) disable iff (rst)
    !reset_req && irq_pending[0] && !vector_relocate_bit
      |=> target_addr == 12'h001 && target_source == 5'h00)
    else $error("ext_irq_zero slot wrong");

  AST_WDT: assert property (@(posedge clk) disable iff (rst)
    !reset_req && irq_pending[5:0] == 6'h20 && !vector_relocate_bit
      |=> target_addr == 12'h006)
    else $error("watchdog slot wrong");

  AST_LAST: assert property (@(posedge clk) disable iff (rst)
    !reset_req && irq_pending == 25'h1000000 && !vector_relocate_bit
      |=> target_addr == 12'h019)
    else $error("store done slot wrong");

  AST_RELOC: assert property (@(posedge clk) disable iff (rst)
    !reset_req && found && vector_relocate_bit
      |=> target_addr == $past(boot_start) + 12'h001
        + 12'(target_source))
    else $error("relocated vector wrong");

  AST_PRIO: assert property (@(posedge clk) disable iff (rst)
    !reset_req && irq_pending[0] |=> target_source == 5'h00
      && target_kind == DISPATCH_IRQ)
    else $error("lowest vector not first");

  AST_IDLE: assert property (@(posedge clk) disable iff (rst)
    !reset_req && irq_pending == 25'h0 |=> !target_valid)
    else $error("dispatch with nothing pending");

  AST_IDLE_ADDR: assert property (@(posedge clk) disable iff (rst)
    !reset_req && irq_pending == 25'h0
      |=> target_addr == 12'h000 && target_source == 5'h00)
    else $error("idle target not cleared");

  AST_EXT1: assert property (@(posedge clk) disable iff (rst)
    !reset_req && irq_pending[1:0] == 2'h2 && !vector_relocate_bit
      |=> target_addr == 12'h002 && target_source == 5'h01)
    else $error("ext_irq_one slot wrong");

  AST_TABLE: assert property (@(posedge clk) disable iff (rst)
    !reset_req && irq_pending != 25'h0 && !vector_relocate_bit
      |=> target_addr == 12'h001 + 12'(target_source))
    else $error("vector slot does not match source");

  AST_LOWEST: assert property (@(posedge clk) disable iff (rst)
    !reset_req && irq_pending != 25'h0
      |=> (irq_vec_type'(1) << target_source)
        == $past(irq_pending & (~irq_pending + 25'h0000001)))
    else $error("winner is not the lowest pending source");

  AST_IRQ_KIND: assert property (@(posedge clk) disable iff (rst)
    !reset_req && irq_pending != 25'h0
      |=> target_valid && target_kind == DISPATCH_IRQ)
    else $error("pending request not dispatched as interrupt");

  AST_RESET_WINS: assert property (@(posedge clk) disable iff (rst)
    reset_req && irq_pending != 25'h0
      |=> target_kind == DISPATCH_RESET && target_source == 5'h00)
    else $error("interrupt dispatched over reset");

  AST_RST_RELOC: assert property (@(posedge clk) disable iff (rst)
    reset_req && boot_reset_fuse && vector_relocate_bit
      |=> target_addr == 12'h000)
    else $error("relocate bit moved the reset address");

  // first cycle after reset release is excluded: outputs still hold reset
  AST_HOLD: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && $stable(reset_req) && $stable(boot_reset_fuse)
      && $stable(vector_relocate_bit) && $stable(boot_start)
      && $stable(irq_pending)
      |=> $stable(target_addr) && $stable(target_source))
    else $error("target changed while inputs stood");

  // ==========================================================
  // scenario covers
  // ==========================================================
  COV_RESET_BOOT: cover property (@(posedge clk) disable iff (rst)
    reset_req && !boot_reset_fuse);
  COV_RELOC: cover property (@(posedge clk) disable iff (rst)
    !reset_req && found && vector_relocate_bit);
  COV_MULTI: cover property (@(posedge clk) disable iff (rst)
    !reset_req && irq_pending[0] && irq_pending[24]);
  COV_RESET_ZERO: cover property (@(posedge clk) disable iff (rst)
    reset_req && boot_reset_fuse);
  COV_LAST_SLOT: cover property (@(posedge clk) disable iff (rst)
    !reset_req && irq_pending == 25'h1000000);

endmodule : interrupt_vector_address_map
`default_nettype wire

// ---- verification/core_fetch_model.sv ----
// Purpose: core fetch side, consumes each presented target
// Assumes: a target is taken in the cycle it is shown
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
// ====
// fetch model
module core_fetch_model
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          target_valid,
  input  wire vector_map_pkg::word_addr_type target_addr,
  output var  vector_map_pkg::word_addr_type fetch_addr
);
  import vector_map_pkg::*;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fetch_addr <= '0;
    else if (target_valid)
      fetch_addr <= target_addr;
  end
endmodule : core_fetch_model
`default_nettype wire

// ---- verification/interrupt_vector_address_map_tb.sv ----
// Purpose: bench for the vector address map
// Assumes: one cycle from inputs to target
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_address_map_tb;
  import vector_map_pkg::*;
  // ====
  // signals
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              reset_req = 1'b0;
  logic              boot_reset_fuse = 1'b1;
  logic              vector_relocate_bit = 1'b0;
  word_addr_type     boot_start = 12'hC00;
  irq_vec_type       irq_pending = '0;
  logic              target_valid;
  dispatch_kind_type target_kind;
  word_addr_type     target_addr;
  logic [4:0]        target_source;
  word_addr_type     fetch_addr;
  int                mismatches = 0;
  int                samples_checked = 0;
  always #20 clk = ~clk;
  interrupt_vector_address_map u_interrupt_vector_address_map
    (.clk(clk), .rst(rst), .reset_req(reset_req),
     .boot_reset_fuse(boot_reset_fuse),
     .vector_relocate_bit(vector_relocate_bit), .boot_start(boot_start),
     .irq_pending(irq_pending), .target_valid(target_valid),
     .target_kind(target_kind), .target_addr(target_addr),
     .target_source(target_source));
  core_fetch_model u_core_fetch_model
    (.clk(clk), .rst(rst), .target_valid(target_valid),
     .target_addr(target_addr), .fetch_addr(fetch_addr));
  // ====
  // tasks
  task automatic final_report();
    $display("mismatches=%0d samples_checked=%0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic check_target(input logic v, input logic k,
    input word_addr_type a, input logic [4:0] s);
    samples_checked++;
    if ({target_valid, target_kind, target_addr, target_source}
        !== {v, k, a, s})
    begin
      mismatches++;
      $display("[ERR] target exp %h got %h", {v, k, a, s},
               {target_valid, target_kind, target_addr, target_source});
    end
  endtask : check_target
  task automatic drive_check(input logic rq, input logic fz,
    input logic rl, input irq_vec_type irq, input logic v,
    input logic k, input word_addr_type a, input logic [4:0] s);
    @(posedge clk);
    #1;
    reset_req = rq;
    boot_reset_fuse = fz;
    vector_relocate_bit = rl;
    irq_pending = irq;
    @(posedge clk);
    #1;
    check_target(v, k, a, s);
    if (v)
    begin
      // fetch side latches the target one edge later
      @(posedge clk);
      #1;
      samples_checked++;
      if (fetch_addr !== a)
      begin
        mismatches++;
        $display("[ERR] fetch_addr exp %h got %h", a, fetch_addr);
      end
    end
  endtask : drive_check
  task automatic t_table();
    drive_check(0, 1, 0, '0, 0, 0, 12'h000, 0);
    for (int i = 0; i < 25; i++)
      drive_check(0, 1, 0, irq_vec_type'(1) << i, 1, 1, 12'(i + 1),
                  5'(i));
  endtask : t_table
  task automatic t_relocate();
    boot_start = 12'h800;
    drive_check(0, 1, 1, 25'h1000000, 1, 1, 12'h819, 24);
    drive_check(0, 0, 1, 25'h0000001, 1, 1, 12'h801, 0);
    drive_check(0, 0, 0, 25'h0000002, 1, 1, 12'h002, 1);
  endtask : t_relocate
  task automatic t_reset_prio();
    boot_start = 12'hC00;
    drive_check(1, 1, 1, '1, 1, 0, 12'h000, 0);
    drive_check(1, 0, 0, '1, 1, 0, 12'hC00, 0);
    drive_check(0, 1, 0, 25'h10000A0, 1, 1, 12'h006, 5);
  endtask : t_reset_prio
  task automatic t_midrun_reset();
    drive_check(0, 1, 0, 25'h0000004, 1, 1, 12'h003, 2);
    rst = 1'b1;
    irq_pending = '0;
    #1;
    check_target(0, 0, 12'h000, 0);
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    check_target(0, 0, 12'h000, 0);
    drive_check(0, 0, 0, 25'h0000004, 1, 1, 12'h003, 2);
  endtask : t_midrun_reset
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    t_table();
    t_relocate();
    t_reset_prio();
    t_midrun_reset();
    final_report();
  end
  initial
  begin
    #20000;
    mismatches++;
    final_report();
  end
endmodule : interrupt_vector_address_map_tb
`default_nettype wire
